// >>> bench/otp_data_path_regs_asserts.sv
`timescale 1ns/1ps

// Port-level checks of the data path register block
module otp_regs_chk #(
  parameter int FIFO_DEPTH  = 4,
  parameter int LEVEL_WIDTH = 3
) (
  input wire logic                   core_clk_in,
  input wire logic                   reset_n_in,
  input wire logic                   clk_en_in,
  input wire logic [31:0]            reg_addr_in,
  input wire logic [31:0]            reg_wdata_in,
  input wire logic                   reg_write_in,
  input wire logic                   reg_read_in,
  input wire logic [31:0]            reg_rdata_out,
  input wire otp_data_path_pkg::otp_mode_t mode_in,
  input wire logic                   dma_enable_in,
  input wire logic                   program_trigger_in,
  input wire logic                   mirror_active_in,
  input wire logic [LEVEL_WIDTH-1:0] fifo_word_count_status_out,
  input wire otp_data_path_pkg::run_cfg_t run_cfg_out,
  input wire logic                   run_cfg_enable_out,
  input wire logic                   read_fill_valid_in,
  input wire logic                   read_fill_ready_out,
  input wire logic                   prog_drain_valid_out,
  input wire logic [31:0]            prog_drain_data_out,
  input wire logic                   prog_drain_ready_in,
  input wire logic                   manual_program_mode_start_out
);
  logic live_q;

  // Past values usable: last cycle out of reset and clocked
  always_ff @(posedge core_clk_in)
    live_q <= reset_n_in & clk_en_in;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Software pop and push at the access port, FIFO side quiet
  sequence pop_s;
    clk_en_in && reg_read_in && reg_addr_in == otp_data_path_pkg::FIFO_ACCESS_PORT_OFS
      && mode_in == otp_data_path_pkg::mode_auto_read && !dma_enable_in && $stable(mode_in)
      && prog_drain_valid_out && !read_fill_valid_in && !prog_drain_ready_in;
  endsequence
  sequence push_s;
    clk_en_in && reg_write_in && reg_addr_in == otp_data_path_pkg::FIFO_ACCESS_PORT_OFS
      && mode_in == otp_data_path_pkg::mode_auto_program && !dma_enable_in && $stable(mode_in)
      && read_fill_ready_out && !read_fill_valid_in && !prog_drain_ready_in;
  endsequence
  // Register write followed by one more clocked cycle
  sequence cfg_wr_s(ofs);
    clk_en_in && reg_write_in && reg_addr_in == ofs && !mirror_active_in ##1 clk_en_in;
  endsequence

  pop_data_a: assert property (
    pop_s |=> reg_rdata_out == $past(prog_drain_data_out)
      && fifo_word_count_status_out == $past(fifo_word_count_status_out) - 1'b1)
    else $error("port read data or level wrong");
  push_level_a: assert property (
    push_s |=> fifo_word_count_status_out == $past(fifo_word_count_status_out) + 1'b1)
    else $error("port write did not push");
  fill_flags_a: assert property (
    read_fill_ready_out == (fifo_word_count_status_out != FIFO_DEPTH)
      && prog_drain_valid_out == (fifo_word_count_status_out != 0))
    else $error("fifo flags disagree with level");
  run_enable_a: assert property (
    live_q |-> run_cfg_enable_out == ($past(mode_in) inside
      {otp_data_path_pkg::mode_auto_read, otp_data_path_pkg::mode_auto_program}))
    else $error("run enable outside automatic modes");
  cell_split_a: assert property (
    cfg_wr_s(otp_data_path_pkg::CELL_WORD_ADDRESS_OFS) |=>
      run_cfg_out.phys_index == 13'($past(reg_wdata_in, 2) >> 1)
      && run_cfg_out.upper_half == 1'($past(reg_wdata_in, 2)))
    else $error("cell address split wrong");
  count_total_a: assert property (
    cfg_wr_s(otp_data_path_pkg::TRANSFER_WORD_COUNT_OFS) |=>
      run_cfg_out.word_total == {1'b0, 14'($past(reg_wdata_in, 2))} + 15'h1)
    else $error("run length not count plus one");
  manual_program_mode_start_a: assert property (
    clk_en_in && program_trigger_in && mode_in == otp_data_path_pkg::mode_manual_program
      |=> manual_program_mode_start_out)
    else $error("manual start missing");
  manual_program_mode_cause_a: assert property (
    live_q && manual_program_mode_start_out |-> $past(program_trigger_in)
      && $past(mode_in) == otp_data_path_pkg::mode_manual_program)
    else $error("manual start without trigger");
endmodule // otp_regs_chk

////////////////////////////////////////////////////////////////////////////////
bind otp_data_path_regs otp_regs_chk #(.FIFO_DEPTH(FIFO_DEPTH), .LEVEL_WIDTH(LEVEL_WIDTH)) chk_u (.*);

// >>> bench/otp_data_path_regs_tb_top.sv
`timescale 1ns/1ps

module otp_data_path_regs_tb_top;
  localparam logic [31:0] CELL  = otp_data_path_pkg::CELL_WORD_ADDRESS_OFS;
  localparam logic [31:0] COUNT = otp_data_path_pkg::TRANSFER_WORD_COUNT_OFS;
  localparam logic [31:0] PORT  = otp_data_path_pkg::FIFO_ACCESS_PORT_OFS;
  localparam logic [31:0] LAST  = otp_data_path_pkg::FIFO_LAST_READ_WORD_OFS;
  localparam logic [31:0] HIGH  = otp_data_path_pkg::PROGRAM_WORD_HIGH_OFS;
  logic                          clk = 1'b0;
  logic                          reset_n, clk_en, reg_write, reg_read, dma, trig, mir_act;
  logic [31:0]                   reg_addr, reg_wdata, reg_rdata, fill_data, drain_data;
  logic [13:0]                   mir_cnt;
  logic [2:0]                    level;
  otp_data_path_pkg::otp_mode_t  mode;
  otp_data_path_pkg::run_cfg_t   run_cfg;
  otp_data_path_pkg::manual_program_mode_cmd_t cmd;
  logic                          run_en, fill_valid, fill_ready, drain_valid, drain_ready;
  logic                          cmd_start, fill_go, drain_go;
  logic [31:0]                   vals [4] = '{32'hFFFFC00B, 32'h00003FFE, 32'hFFFFFFFF, 32'h0};
  int                            error_cnt = 0;
  int                            checked = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  otp_data_path_regs dut_u (
    .core_clk_in(clk), .reset_n_in(reset_n), .clk_en_in(clk_en),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
    .reg_read_in(reg_read), .reg_rdata_out(reg_rdata), .mode_in(mode),
    .dma_enable_in(dma), .program_trigger_in(trig), .mirror_active_in(mir_act),
    .mirror_count_in(mir_cnt), .fifo_word_count_status_out(level), .run_cfg_out(run_cfg),
    .run_cfg_enable_out(run_en), .read_fill_valid_in(fill_valid),
    .read_fill_data_in(fill_data), .read_fill_ready_out(fill_ready),
    .prog_drain_valid_out(drain_valid), .prog_drain_data_out(drain_data),
    .prog_drain_ready_in(drain_ready), .manual_program_mode_cmd_out(cmd), .manual_program_mode_start_out(cmd_start)
  );
  otp_seq_model sq_u (
    .core_clk_in(clk), .fill_go_in(fill_go), .drain_go_in(drain_go),
    .fill_ready_in(fill_ready), .fill_valid_out(fill_valid), .fill_data_out(fill_data),
    .drain_valid_in(drain_valid), .drain_data_in(drain_data), .drain_ready_out(drain_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic set_mode(input otp_data_path_pkg::otp_mode_t m);
    @(posedge clk);
    mode <= m;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Address and count written, read back, run set-up checked
  task automatic cfg_case(input logic [31:0] v);
    wr(CELL, v);
    wr(COUNT, v);
    rd(CELL, {18'h0, v[13:0]}, "cell");
    rd(COUNT, {18'h0, v[13:0]}, "count");
    chk("index", {19'h0, v[13:1]}, 32'(run_cfg.phys_index));
    chk("half", {31'h0, v[0]}, 32'(run_cfg.upper_half));
    chk("total", 32'(v[13:0]) + 32'h1, 32'(run_cfg.word_total));
    chk("run enable", 32'h1, 32'(run_en));
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    reset_n   = 1'b0;
    clk_en    = 1'b1;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    reg_addr  = 32'h0;
    reg_wdata = 32'h0;
    mode      = otp_data_path_pkg::mode_other;
    dma       = 1'b0;
    trig      = 1'b0;
    mir_act   = 1'b0;
    mir_cnt   = 14'h0123;
    fill_go   = 1'b0;
    drain_go  = 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(CELL + 32'(4 * i), 32'h0, "reset value");
    set_mode(otp_data_path_pkg::mode_auto_read);
    foreach (vals[i]) cfg_case(vals[i]);
    set_mode(otp_data_path_pkg::mode_other);
    chk("run enable", 32'h0, 32'(run_en));
    @(posedge clk);
    mir_act <= 1'b1;
    wr(COUNT, 32'h7);
    rd(COUNT, 32'h123, "mirror count");
    @(posedge clk);
    mir_act <= 1'b0;
    rd(COUNT, 32'h123, "count kept");
    set_mode(otp_data_path_pkg::mode_auto_program);
    @(posedge clk);
    dma <= 1'b1;
    wr(PORT, 32'h5A5A5A5A);
    @(posedge clk);
    dma <= 1'b0;
    #1;
    chk("dma level", 32'h0, 32'(level));
    for (int i = 0; i < 5; i++) wr(PORT, 32'hC0DE0000 + 32'(i));
    #1;
    chk("full level", 32'h4, 32'(level));
    @(posedge clk);
    drain_go <= 1'b1;
    for (int t = 0; t < 20 && sq_u.got_cnt != 3'h4; t++) @(posedge clk);
    for (int i = 0; i < 4; i++) chk("drained", 32'hC0DE0000 + 32'(i), sq_u.got[i]);
    drain_go <= 1'b0;
    set_mode(otp_data_path_pkg::mode_auto_read);
    @(posedge clk);
    fill_go <= 1'b1;
    for (int t = 0; t < 20 && level != 3'h4; t++) @(posedge clk) #1;
    for (int i = 0; i < 4; i++)
    begin
      chk("level", 32'(4 - i), 32'(level));
      rd(PORT, 32'hA5A50000 + 32'(i), "port word");
      rd(LAST, 32'hA5A50000 + 32'(i), "last word");
    end
    rd(PORT, 32'h0, "empty port");
    wr(LAST, 32'hFFFFFFFF);
    rd(LAST, 32'hA5A50003, "last kept");
    set_mode(otp_data_path_pkg::mode_manual_program);
    wr(otp_data_path_pkg::PROGRAM_WORD_LOW_OFS, 32'h89ABCDEF);
    wr(HIGH, 32'h01234567);
    wr(CELL, 32'h00000009);
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    #1;
    chk("start", 32'h1, 32'(cmd_start));
    chk("low", 32'h89ABCDEF, cmd.data[31:0]);
    chk("high", 32'h01234567, cmd.data[63:32]);
    chk("cmd index", 32'h4, 32'(cmd.phys_index));
    @(posedge clk);
    #1;
    chk("start end", 32'h0, 32'(cmd_start));
    wr(32'h07F40028, 32'hFFFFFFFF);
    rd(32'h07F40028, 32'h0, "unmapped");
    rd(HIGH, 32'h01234567, "high kept");
    final_report;
  end

  // Watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH watchdog exp finish got timeout");
    final_report;
  end
endmodule // otp_data_path_regs_tb_top

// >>> bench/otp_seq_model.sv
`timescale 1ns/1ps

// Array sequencer stand-in: fills the FIFO and drains it
module otp_seq_model #(
  parameter logic [31:0] FILL_BASE = 32'hA5A50000
) (
  input  wire logic        core_clk_in,
  input  wire logic        fill_go_in,
  input  wire logic        drain_go_in,
  input  wire logic        fill_ready_in,
  output logic             fill_valid_out,
  output logic [31:0]      fill_data_out,
  input  wire logic        drain_valid_in,
  input  wire logic [31:0] drain_data_in,
  output logic             drain_ready_out
);
  logic [2:0]  fill_idx;
  logic [2:0]  got_cnt;
  logic [31:0] got [4];

  // Offer four words; inverted data while nothing is offered
  assign fill_valid_out  = fill_go_in && fill_idx < 3'h4;
  assign fill_data_out   = fill_valid_out ? FILL_BASE + 32'(fill_idx) : ~(FILL_BASE + 32'(fill_idx));
  assign drain_ready_out = drain_go_in && got_cnt < 3'h4;

  // Offer held until taken, restart when filling stops
  always @(posedge core_clk_in)
    if (!fill_go_in)
      fill_idx <= 3'h0;
    else if (fill_valid_out && fill_ready_in)
      fill_idx <= fill_idx + 3'h1;

  // Store drained words in arrival order
  always @(posedge core_clk_in)
    if (!drain_go_in)
      got_cnt <= 3'h0;
    else if (drain_valid_in && drain_ready_out)
    begin
      got[got_cnt[1:0]] <= drain_data_in;
      got_cnt           <= got_cnt + 3'h1;
    end
endmodule // otp_seq_model

// >>> core/otp_data_path_pkg.sv
package otp_data_path_pkg;

  // Register byte addresses
  localparam logic [31:0] CELL_WORD_ADDRESS_OFS   = 32'h07F40010;
  localparam logic [31:0] TRANSFER_WORD_COUNT_OFS = 32'h07F40014;
  localparam logic [31:0] FIFO_ACCESS_PORT_OFS    = 32'h07F40018;
  localparam logic [31:0] FIFO_LAST_READ_WORD_OFS = 32'h07F4001C;
  localparam logic [31:0] PROGRAM_WORD_LOW_OFS    = 32'h07F40020;
  localparam logic [31:0] PROGRAM_WORD_HIGH_OFS   = 32'h07F40024;

  // Field layout of the address and count registers
  localparam int          CELL_ADDR_WIDTH  = 14;
  localparam int          WORD_COUNT_WIDTH = 14;
  localparam int          HALF_SELECT_BIT  = 0;
  localparam int          PHYS_INDEX_WIDTH = 13;

  // Physical array word: data plus hidden correction bits
  localparam int          PHYS_WORD_WIDTH = 72;
  localparam int          ECC_WIDTH       = 8;
  localparam int          APP_DATA_WIDTH  = 64;
  localparam int          APP_WORD_WIDTH  = 32;

  // Values after reset, and the value read at unmapped addresses
  localparam logic [31:0] CELL_WORD_ADDRESS_RST   = 32'h00000000;
  localparam logic [31:0] TRANSFER_WORD_COUNT_RST = 32'h00000000;
  localparam logic [31:0] FIFO_LAST_READ_WORD_RST = 32'h00000000;
  localparam logic [31:0] PROGRAM_WORD_LOW_RST    = 32'h00000000;
  localparam logic [31:0] PROGRAM_WORD_HIGH_RST   = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ_VALUE     = 32'h00000000;

  // FIFO sizing
  localparam int          FIFO_DEPTH = 4;

  // Operating mode chosen by the mode control logic
  typedef enum logic [1:0] {
    mode_other,
    mode_auto_read,
    mode_auto_program,
    mode_manual_program
  } otp_mode_t;

  // Start point and length of an automatic run
  typedef struct packed {
    logic [PHYS_INDEX_WIDTH-1:0] phys_index;
    logic                        upper_half;
    logic [WORD_COUNT_WIDTH:0]   word_total;
  } run_cfg_t;

  // One manual programming command
  typedef struct packed {
    logic [PHYS_INDEX_WIDTH-1:0] phys_index;
    logic [APP_DATA_WIDTH-1:0]   data;
  } manual_program_mode_cmd_t;

endpackage

// >>> core/otp_data_path_regs.sv
// Behaviour
// - Cell address counts 32-bit application words, not physical array words.
// - Physical word is 72 bits: 8 hidden correction bits, 64 data bits.
// - Address bit zero picks the upper half; upper bits give physical index.
// - Cell address is the start point only in automatic read or program.
// - An automatic run moves word count plus one 32-bit words.
// - Logic never changes word count, except mirroring shows copied amount.
// - Automatic program without DMA: port writes push words into the FIFO.
// - Automatic read without DMA: port reads pop and return the next word.
// - Each port read also leaves the popped word in a read-only register.
// - Manual programming takes the low 32 bits from the low holding word.
// - Manual programming takes the high 32 bits from the high holding word.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Small synchronous FIFO with registered flags
module otp_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4,
  parameter int LEVEL_WIDTH = $clog2(DEPTH + 1)
) (
  input  wire logic                   core_clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic                   clk_en_in,
  input  wire logic                   flush_in,
  input  wire logic                   in_valid_in,
  output logic                        in_ready_out,
  input  wire logic [WIDTH-1:0]       in_data_in,
  output logic                        out_valid_out,
  input  wire logic                   out_ready_in,
  output logic [WIDTH-1:0]            out_data_out,
  output logic [LEVEL_WIDTH-1:0]      level_out
);

  localparam int PTR_WIDTH = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0]       store_q [DEPTH];
  logic [PTR_WIDTH-1:0]   wr_ptr_q;
  logic [PTR_WIDTH-1:0]   rd_ptr_q;
  logic [LEVEL_WIDTH-1:0] level_q;
  logic                   in_ready_q;
  logic                   out_valid_q;
  logic                   push;
  logic                   pop;
  logic [LEVEL_WIDTH-1:0] level_d;

  // Pointer advance with wrap at the configured depth
  function automatic logic [PTR_WIDTH-1:0] next_ptr(input logic [PTR_WIDTH-1:0] ptr);
    if (ptr == PTR_WIDTH'(DEPTH - 1))
      return '0;
    return ptr + PTR_WIDTH'(1);
  endfunction

  // Handshakes on both sides
  assign push = in_valid_in && in_ready_q && !flush_in;
  assign pop  = out_ready_in && out_valid_q && !flush_in;

  // Next fill level
  always_comb
  begin
    level_d = level_q;
    if (flush_in)
      level_d = '0;
    else if (push && !pop)
      level_d = level_q + LEVEL_WIDTH'(1);
    else if (pop && !push)
      level_d = level_q - LEVEL_WIDTH'(1);
  end

  // Storage writes
  always_ff @(posedge core_clk_in)
  begin
    if (clk_en_in && push)
      store_q[wr_ptr_q] <= in_data_in;
  end

  // Pointers, level and flags
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      level_q  <= '0;
      in_ready_q  <= 1'b1;
      out_valid_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (flush_in)
      begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
      end
      else
      begin
        if (push)
          wr_ptr_q <= next_ptr(wr_ptr_q);
        if (pop)
          rd_ptr_q <= next_ptr(rd_ptr_q);
      end
      level_q <= level_d;
      in_ready_q  <= (level_d != LEVEL_WIDTH'(DEPTH));
      out_valid_q <= (level_d != '0);
    end
  end

  assign in_ready_out  = in_ready_q;
  assign out_valid_out = out_valid_q;
  assign out_data_out  = store_q[rd_ptr_q];
  assign level_out     = level_q;

endmodule // otp_word_fifo

////////////////////////////////////////////////////////////////////////////////
// Address, count, FIFO port and holding-word registers of the OTP controller
module otp_data_path_regs #(
  parameter int FIFO_DEPTH  = otp_data_path_pkg::FIFO_DEPTH,
  parameter int LEVEL_WIDTH = $clog2(FIFO_DEPTH + 1)
) (
  input  wire logic                                     core_clk_in,
  input  wire logic                                     reset_n_in,
  input  wire logic                                     clk_en_in,
  // Register port
  input  wire logic [31:0]                              reg_addr_in,
  input  wire logic [31:0]                              reg_wdata_in,
  input  wire logic                                     reg_write_in,
  input  wire logic                                     reg_read_in,
  output logic [31:0]                                   reg_rdata_out,
  // From the mode control and status logic
  input  wire otp_data_path_pkg::otp_mode_t             mode_in,
  input  wire logic                                     dma_enable_in,
  input  wire logic                                     program_trigger_in,
  input  wire logic                                     mirror_active_in,
  input  wire logic [otp_data_path_pkg::WORD_COUNT_WIDTH-1:0] mirror_count_in,
  output logic [LEVEL_WIDTH-1:0]                        fifo_word_count_status_out,
  // Automatic run set-up towards the array sequencer
  output otp_data_path_pkg::run_cfg_t                   run_cfg_out,
  output logic                                          run_cfg_enable_out,
  // Automatic read: sequencer fills the FIFO
  input  wire logic                                     read_fill_valid_in,
  input  wire logic [31:0]                              read_fill_data_in,
  output logic                                          read_fill_ready_out,
  // Automatic program: sequencer drains the FIFO
  output logic                                          prog_drain_valid_out,
  output logic [31:0]                                   prog_drain_data_out,
  input  wire logic                                     prog_drain_ready_in,
  // Manual programming command
  output otp_data_path_pkg::manual_program_mode_cmd_t                 manual_program_mode_cmd_out,
  output logic                                          manual_program_mode_start_out
);

  localparam int CW = otp_data_path_pkg::CELL_ADDR_WIDTH;
  localparam int NW = otp_data_path_pkg::WORD_COUNT_WIDTH;

  logic [CW-1:0]            cell_word_address_q;
  logic [NW-1:0]            transfer_word_count_q;
  logic [31:0]              fifo_last_read_word_q;
  logic [31:0]              program_word_low_q;
  logic [31:0]              program_word_high_q;
  logic [31:0]              rdata_q;
  otp_data_path_pkg::otp_mode_t mode_q;
  otp_data_path_pkg::run_cfg_t  run_cfg_q;
  otp_data_path_pkg::manual_program_mode_cmd_t manual_program_mode_cmd_q;
  logic                     run_cfg_enable_q;
  logic                     manual_program_mode_start_q;

  logic                     sel_addr;
  logic                     sel_count;
  logic                     sel_port;
  logic                     sel_last;
  logic                     sel_low;
  logic                     sel_high;
  logic                     port_push;
  logic                     port_pop;
  logic                     fifo_flush;
  logic                     fifo_in_valid;
  logic [31:0]              fifo_in_data;
  logic                     fifo_in_ready;
  logic                     fifo_out_valid;
  logic                     fifo_out_ready;
  logic [31:0]              fifo_out_data;
  logic [LEVEL_WIDTH-1:0]   fifo_level;
  logic [31:0]              read_mux;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign sel_addr  = (reg_addr_in == otp_data_path_pkg::CELL_WORD_ADDRESS_OFS);
  assign sel_count = (reg_addr_in == otp_data_path_pkg::TRANSFER_WORD_COUNT_OFS);
  assign sel_port  = (reg_addr_in == otp_data_path_pkg::FIFO_ACCESS_PORT_OFS);
  assign sel_last  = (reg_addr_in == otp_data_path_pkg::FIFO_LAST_READ_WORD_OFS);
  assign sel_low   = (reg_addr_in == otp_data_path_pkg::PROGRAM_WORD_LOW_OFS);
  assign sel_high  = (reg_addr_in == otp_data_path_pkg::PROGRAM_WORD_HIGH_OFS);

  //////////////////////////////////////////////////////////////////////////////
  // FIFO access port
  // program mode push, read mode pop
  assign port_push = reg_write_in && sel_port && !dma_enable_in
                     && (mode_in == otp_data_path_pkg::mode_auto_program);
  assign port_pop  = reg_read_in && sel_port && !dma_enable_in
                     && (mode_in == otp_data_path_pkg::mode_auto_read);

  // A mode change empties the FIFO; a port read in that same cycle still returns the old head word
  assign fifo_flush = (mode_in != mode_q);

  // Filling side: software or DMA in program mode, sequencer in read mode
  always_comb
  begin
    fifo_in_valid = 1'b0;
    fifo_in_data  = port_push ? reg_wdata_in : read_fill_data_in;
    if (mode_in == otp_data_path_pkg::mode_auto_program)
      fifo_in_valid = port_push || (dma_enable_in && read_fill_valid_in);
    else if (mode_in == otp_data_path_pkg::mode_auto_read)
      fifo_in_valid = read_fill_valid_in;
  end

  // Draining side: sequencer in program mode, software or DMA in read mode
  always_comb
  begin
    fifo_out_ready = 1'b0;
    if (mode_in == otp_data_path_pkg::mode_auto_program)
      fifo_out_ready = prog_drain_ready_in;
    else if (mode_in == otp_data_path_pkg::mode_auto_read)
      fifo_out_ready = dma_enable_in ? prog_drain_ready_in : port_pop;
  end

  otp_word_fifo #(
    .WIDTH       (32),
    .DEPTH       (FIFO_DEPTH),
    .LEVEL_WIDTH (LEVEL_WIDTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .reset_n_in    (reset_n_in),
    .clk_en_in     (clk_en_in),
    .flush_in      (fifo_flush),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (fifo_in_data),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data),
    .level_out     (fifo_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Mode tracking for the flush
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      mode_q <= otp_data_path_pkg::mode_other;
    else if (clk_en_in)
      mode_q <= mode_in;
  end

  // Cell address register
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      cell_word_address_q <= otp_data_path_pkg::CELL_WORD_ADDRESS_RST[CW-1:0];
    else if (clk_en_in && reg_write_in && sel_addr)
      cell_word_address_q <= reg_wdata_in[CW-1:0];
  end

  // Word count register
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      transfer_word_count_q <= otp_data_path_pkg::TRANSFER_WORD_COUNT_RST[NW-1:0];
    else if (clk_en_in)
    begin
      if (mirror_active_in)
        transfer_word_count_q <= mirror_count_in;
      else if (reg_write_in && sel_count)
        transfer_word_count_q <= reg_wdata_in[NW-1:0];
    end
  end

  // Holding words for manual programming
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      program_word_low_q  <= otp_data_path_pkg::PROGRAM_WORD_LOW_RST;
      program_word_high_q <= otp_data_path_pkg::PROGRAM_WORD_HIGH_RST;
    end
    else if (clk_en_in && reg_write_in)
    begin
      if (sel_low)
        program_word_low_q <= reg_wdata_in;
      if (sel_high)
        program_word_high_q <= reg_wdata_in;
    end
  end

  // Copy of the last word popped by a port read
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      fifo_last_read_word_q <= otp_data_path_pkg::FIFO_LAST_READ_WORD_RST;
    else if (clk_en_in && port_pop && fifo_out_valid)
      fifo_last_read_word_q <= fifo_out_data;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data mux
  always_comb
  begin
    read_mux = otp_data_path_pkg::UNMAPPED_READ_VALUE;
    if (sel_addr)
      read_mux = {{(32 - CW){1'b0}}, cell_word_address_q};
    else if (sel_count)
      read_mux = {{(32 - NW){1'b0}}, transfer_word_count_q};
    else if (sel_port)
      read_mux = (port_pop && fifo_out_valid) ? fifo_out_data : 32'h00000000;
    else if (sel_last)
      read_mux = fifo_last_read_word_q;
    else if (sel_low)
      read_mux = program_word_low_q;
    else if (sel_high)
      read_mux = program_word_high_q;
  end

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
      rdata_q <= 32'h00000000;
    else if (clk_en_in)
      rdata_q <= reg_read_in ? read_mux : 32'h00000000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Automatic run set-up
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      run_cfg_q        <= '0;
      run_cfg_enable_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      run_cfg_q.upper_half <= cell_word_address_q[otp_data_path_pkg::HALF_SELECT_BIT];
      run_cfg_q.phys_index <= cell_word_address_q[CW-1:1];
      run_cfg_q.word_total <= {1'b0, transfer_word_count_q} + (NW + 1)'(1);
      run_cfg_enable_q <= (mode_in == otp_data_path_pkg::mode_auto_read)
                          || (mode_in == otp_data_path_pkg::mode_auto_program);
    end
  end

  // Manual programming command capture
  always_ff @(posedge core_clk_in)
  begin
    if (!reset_n_in)
    begin
      manual_program_mode_cmd_q   <= '0;
      manual_program_mode_start_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      manual_program_mode_start_q <= 1'b0;
      if (program_trigger_in && mode_in == otp_data_path_pkg::mode_manual_program)
      begin
        // 64 data bits, correction added downstream
        manual_program_mode_cmd_q.data       <= {program_word_high_q, program_word_low_q};
        manual_program_mode_cmd_q.phys_index <= cell_word_address_q[CW-1:1];
        manual_program_mode_start_q          <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata_out              = rdata_q;
  assign run_cfg_out                = run_cfg_q;
  assign run_cfg_enable_out         = run_cfg_enable_q;
  assign manual_program_mode_cmd_out              = manual_program_mode_cmd_q;
  assign manual_program_mode_start_out            = manual_program_mode_start_q;
  assign fifo_word_count_status_out = fifo_level;
  assign read_fill_ready_out        = fifo_in_ready;   // Registered not-full flag
  assign prog_drain_valid_out       = fifo_out_valid;  // Registered not-empty flag
  assign prog_drain_data_out        = fifo_out_data;

endmodule // otp_data_path_regs
